//--- inc/ext_bus_params.svh
// Constants for the external memory bus strobe block
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH
`define BUS_RESET_VEC_LO 16'h0000
`define BUS_RESET_VEC_HI 16'h0001
`define BUS_T_STROBE_NS  50
`define BUS_STROBE_CYC   ((`BUS_T_STROBE_NS + 49) / 50)
`endif

//--- inc/ext_bus_pkg.sv
// Types for the external memory bus strobe block
package ext_bus_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_HOLD, ST_DATA, ST_END
   } bus_state_e;
   typedef struct packed {
      logic        write;
      logic        data_space;
      logic        internal;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } bus_req_s;
   typedef struct packed {
      logic [7:0] p0_out;
      logic [7:0] p0_oe_n;
      logic [7:0] p1_out;
      logic [7:0] p1_oe_n;
      logic [7:0] p6_out;
      logic [7:0] p6_oe_n;
   } bus_pins_s;
endpackage

//--- rtl/ext_bus_strobes.sv
// External memory bus master: strobes, direction, multiplexed ports
`timescale 1ns/1ps
`include "ext_bus_params.svh"

// Functional notes
// [RL1] One low address strobe pulse per cycle
// [RL2] Address, direction, space valid at strobe rise
// [RL3] Software float of strobes, direction, ports
// [RL4] Data strobe times port 0 data
// [RL5] Write data valid by strobe fall
// [RL6] Memory drives read data before strobe rise
// [RL7] Internal cycles keep data strobe high
// [RL8] Direction low only for external writes
// [RL9] Direction floats with ports 0,1,6
// [RL10] Fetch reset vector from locations 0,1
// [RL11] Ports 0,1,6: data, high, low address
// [RL12] Data strobe only after address strobe ends
module ext_bus_strobes
   import ext_bus_pkg::*;
(
   input  wire logic       clk,             // 20 MHz clock
   input  wire logic       rst_b,           // Async reset, active low
   input  wire logic       bus_float,       // Release the bus
   input  wire logic       req_valid,       // Cycle request
   input  wire bus_req_s   req,             // Cycle description
   output logic            req_ready,       // Request accepted
   output logic            rsp_valid,       // Cycle done pulse
   output logic [7:0]      rsp_rdata,       // Read data
   output logic            vec_done,        // Reset vector loaded
   output logic [15:0]     start_addr,      // Start address from vector
   output logic            address_strobe_n,// Address strobe out
   output logic            as_oe_n,         // Address strobe enable, low drives
   output logic            data_strobe_n,   // Data strobe out
   output logic            ds_oe_n,         // Data strobe enable, low drives
   output logic            rw,              // High read, low write
   output logic            rw_oe_n,         // Direction enable, low drives
   output logic            data_space,      // Data memory select
   output bus_pins_s       pins,            // Ports 0, 1, 6 drive
   input  wire logic [7:0] p0_in            // Port 0 input
);

   ////////////////////////////////////////////////////////////////////////
   localparam logic [3:0] STROBE_CYC = 4'(`BUS_STROBE_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Cycle walk, one clock per step
   //   Idle: request taken, address strobe falls
   //   Idle: high address on port 1, low on 6 and 0
   //   Idle: direction and space select set here
   //   Addr: address strobe rises, all address lines stable
   //   Addr: external latch captures address on that rise
   //   Hold: port 0 turns round to write data or input
   //   Hold: data strobe falls unless cycle is internal
   //   Data: data strobe rises, port 0 sampled on every cycle
   //   End:  direction back high, response pulse registered
   // A user cycle takes four clocks plus one idle clock.
   // Limitation: strobes are whole clocks wide, one clock
   // at the nominal rate; there is no wait input, so slow
   // memories need a slower clock instead.
   // Float is only honoured in idle, so no strobe is cut
   // short and no half cycle reaches the memory.
   // Reset: strobes and direction high, enables driving,
   // port 0 floated; the vector fetch follows at once.
   // Vector: location zero gives the high start byte,
   // location one the low start byte.
   // Trade-off: the vector fetch reuses the normal read
   // path, so it costs two full cycles but no extra logic.

   bus_state_e  state_r, state_nxt;
   bus_req_s    cur_r, cur_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [1:0]  vec_r, vec_nxt;       // 0,1 fetching vector, 2 done
   logic        as_r, as_nxt;
   logic        ds_r, ds_nxt;
   logic        rw_r, rw_nxt;
   logic        dsp_r, dsp_nxt;
   logic        flt_r, flt_nxt;
   logic        rdy_r, rdy_nxt;
   logic        rsp_r, rsp_nxt;
   logic [7:0]  rd_r, rd_nxt;
   logic [15:0] sa_r, sa_nxt;
   bus_pins_s   pins_r, pins_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Cycle sequencer; vector fetch takes priority after reset
   always_comb begin
      state_nxt = state_r;
      cur_nxt   = cur_r;
      cnt_nxt   = cnt_r;
      vec_nxt   = vec_r;
      as_nxt    = 1'b1;
      ds_nxt    = 1'b1;
      rw_nxt    = rw_r;
      dsp_nxt   = dsp_r;
      rdy_nxt   = 1'b0;
      rsp_nxt   = 1'b0;
      rd_nxt    = rd_r;
      sa_nxt    = sa_r;
      pins_nxt  = pins_r;
      // [RL3] Float on command
      flt_nxt   = bus_float && state_r == ST_IDLE ? 1'b1 : (state_r == ST_IDLE ? 1'b0 : flt_r);
      case (state_r)
         ST_IDLE: begin
            if (!bus_float) begin
               if (vec_r != 2'd2) begin
                  // [RL10] Reset vector fetch
                  cur_nxt = '{write: 1'b0, data_space: 1'b0, internal: 1'b0,
                              addr: (vec_r == 2'd0) ? `BUS_RESET_VEC_LO : `BUS_RESET_VEC_HI,
                              wdata: 8'h00};
                  state_nxt = ST_ADDR;
               end else if (req_valid && !rdy_r) begin
                  cur_nxt   = req;
                  rdy_nxt   = 1'b1;
                  state_nxt = ST_ADDR;
               end
               if (state_nxt == ST_ADDR) begin
                  // [RL1] Single strobe pulse
                  as_nxt  = 1'b0;
                  cnt_nxt = STROBE_CYC;
                  // [RL8] Direction low for external writes
                  rw_nxt  = !((vec_r == 2'd2) && req.write && !req.internal);
                  dsp_nxt = (vec_r == 2'd2) ? req.data_space : 1'b0;
                  // [RL11] Address on ports 1, 6, 0
                  pins_nxt.p1_out  = cur_nxt.addr[15:8];
                  pins_nxt.p6_out  = cur_nxt.addr[7:0];
                  pins_nxt.p0_out  = cur_nxt.addr[7:0];
                  pins_nxt.p0_oe_n = 8'h00;
               end
            end
         end
         ST_ADDR: begin
            // Strobe held low; rises with address still stable
            if (cnt_r > 4'd1) begin
               as_nxt  = 1'b0;
               cnt_nxt = cnt_r - 4'd1;
            end else begin
               // [RL2] Address held through rise
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // [RL12] Gap before data strobe
            cnt_nxt = STROBE_CYC;
            state_nxt = ST_DATA;
            // [RL7] Internal cycle keeps strobe high
            ds_nxt = cur_r.internal;
            if (cur_r.write) begin
               // [RL5] Write data driven on the same edge as strobe fall
               pins_nxt.p0_out  = cur_r.wdata;
               pins_nxt.p0_oe_n = 8'h00;
            end else begin
               pins_nxt.p0_oe_n = 8'hFF;
            end
         end
         ST_DATA: begin
            if (cnt_r > 4'd1) begin
               ds_nxt  = cur_r.internal;
               cnt_nxt = cnt_r - 4'd1;
            end else begin
               // [RL4] Sample on strobe rise
               // [RL6] Memory data already valid here
               rd_nxt    = p0_in;
               state_nxt = ST_END;
            end
         end
         ST_END: begin
            rw_nxt    = 1'b1;
            state_nxt = ST_IDLE;
            if (vec_r == 2'd0) begin
               sa_nxt[15:8] = rd_r;
               vec_nxt = 2'd1;
            end else if (vec_r == 2'd1) begin
               sa_nxt[7:0] = rd_r;
               vec_nxt = 2'd2;
            end else begin
               rsp_nxt = 1'b1;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer state registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         cur_r   <= '0;
         cnt_r   <= 4'h0;
         vec_r   <= 2'd0;
      end else begin
         state_r <= state_nxt;
         cur_r   <= cur_nxt;
         cnt_r   <= cnt_nxt;
         vec_r   <= vec_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Strobe, direction and pin registers; strobes idle high from reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         as_r    <= 1'b1;
         ds_r    <= 1'b1;
         rw_r    <= 1'b1;
         dsp_r   <= 1'b0;
         flt_r   <= 1'b0;
         pins_r  <= '{p0_out: 8'h00, p0_oe_n: 8'hFF, p1_out: 8'h00, p1_oe_n: 8'h00,
                      p6_out: 8'h00, p6_oe_n: 8'h00};
      end else begin
         as_r    <= as_nxt;
         ds_r    <= ds_nxt;
         rw_r    <= rw_nxt;
         dsp_r   <= dsp_nxt;
         flt_r   <= flt_nxt;
         pins_r  <= pins_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Handshake, read data and start address registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdy_r   <= 1'b0;
         rsp_r   <= 1'b0;
         rd_r    <= 8'h00;
         sa_r    <= 16'h0000;
      end else begin
         rdy_r   <= rdy_nxt;
         rsp_r   <= rsp_nxt;
         rd_r    <= rd_nxt;
         sa_r    <= sa_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output enables: float only between cycles, so no strobe is cut short
   logic       oe_n_r;
   logic [7:0] p0oe_r;
   logic       oe_n_nxt;
   logic [7:0] p0oe_nxt;
   always_comb begin
      // [RL9] Direction floats with bus
      oe_n_nxt = flt_nxt;
      p0oe_nxt = flt_nxt ? 8'hFF : pins_nxt.p0_oe_n;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oe_n_r <= 1'b0;
         p0oe_r <= 8'hFF;
      end else begin
         oe_n_r <= oe_n_nxt;
         p0oe_r <= p0oe_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Vector done flag, kept in its own flop so the output is registered
   logic vdone_r;
   logic vdone_nxt;
   always_comb begin
      vdone_nxt = (vec_nxt == 2'd2);
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vdone_r <= 1'b0;
      end else begin
         vdone_r <= vdone_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-bit enables of ports 1 and 6 follow the common float flop
   logic [7:0] p1oe_w;
   logic [7:0] p6oe_w;
   for (genvar gi = 0; gi < 8; gi++) begin : g_addr_oe
      assign p1oe_w[gi] = oe_n_r;
      assign p6oe_w[gi] = oe_n_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // Handshake and vector outputs
   assign req_ready        = rdy_r;
   assign rsp_valid        = rsp_r;
   assign rsp_rdata        = rd_r;
   assign vec_done         = vdone_r;
   assign start_addr       = sa_r;

   // Bus pin outputs; every enable is low while driving
   assign address_strobe_n = as_r;
   assign as_oe_n          = oe_n_r;
   assign data_strobe_n    = ds_r;
   assign ds_oe_n          = oe_n_r;
   assign rw               = rw_r;
   assign rw_oe_n          = oe_n_r;
   assign data_space       = dsp_r;
   assign pins             = '{p0_out: pins_r.p0_out, p0_oe_n: p0oe_r,
                               p1_out: pins_r.p1_out, p1_oe_n: p1oe_w,
                               p6_out: pins_r.p6_out, p6_oe_n: p6oe_w};

endmodule // ext_bus_strobes

//--- verification/bus_chk.sv
// Assertion checker for the external bus strobes
`timescale 1ns/1ps
module bus_chk
   import ext_bus_pkg::*;
(
   input wire logic      clk,              // Clock
   input wire logic      rst_b,            // Reset
   input wire logic      req_valid,        // Request
   input wire bus_req_s  req,              // Request fields
   input wire logic      req_ready,        // Taken
   input wire logic      vec_done,         // Vector loaded
   input wire logic      address_strobe_n, // Address strobe
   input wire logic      as_oe_n,          // Strobe enable
   input wire logic      data_strobe_n,    // Data strobe
   input wire logic      ds_oe_n,          // Strobe enable
   input wire logic      rw,               // Direction
   input wire logic      rw_oe_n,          // Direction enable
   input wire logic      data_space,       // Space select
   input wire bus_pins_s pins              // Ports
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Cycle steps
   sequence s_as_fall; $fell(address_strobe_n); endsequence
   sequence s_ds_fall; $fell(data_strobe_n); endsequence
   a_as_pulse: assert property (s_as_fall |=> $rose(address_strobe_n))
      else $error("address strobe wider than one cycle");
   a_addr_valid: assert property ($rose(address_strobe_n) |-> $stable(pins.p1_out) && $stable(rw) && $stable(data_space))
      else $error("address moved at strobe rise");
   a_port_map: assert property ($rose(address_strobe_n) |-> pins.p0_out == pins.p6_out && pins.p0_oe_n == 8'h00)
      else $error("low address missing on port 0");
   a_oe_group: assert property (ds_oe_n == as_oe_n && rw_oe_n == as_oe_n && pins.p1_oe_n == {8{as_oe_n}} && pins.p6_oe_n == {8{as_oe_n}})
      else $error("bus lines not floated together");
   a_ds_order: assert property (s_ds_fall |-> address_strobe_n && $past(address_strobe_n))
      else $error("data strobe before address strobe ended");
   a_ds_pulse: assert property (s_ds_fall |=> $rose(data_strobe_n))
      else $error("data strobe wider than one cycle");
   a_wr_data: assert property ((s_ds_fall and !rw) |-> pins.p0_oe_n == 8'h00)
      else $error("write data not driven at strobe");
   a_rw_cause: assert property ($fell(rw) |-> $past(req_valid && req.write && !req.internal))
      else $error("direction low without external write");
   a_int_quiet: assert property (req_ready && $past(req.internal) |-> data_strobe_n [*5])
      else $error("data strobe on internal cycle");
   a_vec_first: assert property (req_ready |-> vec_done)
      else $error("request taken before vector fetch");
endmodule // bus_chk

//--- verification/mem_model.sv
// Behavioural external memory on the multiplexed bus
`timescale 1ns/1ps
module mem_model
   import ext_bus_pkg::*;
(
   input  wire logic      clk,  // Clock
   input  wire logic      as_n, // Address strobe
   input  wire logic      ds_n, // Data strobe
   input  wire logic      rw,   // Direction
   input  wire bus_pins_s pins, // Ports
   output logic [7:0]     rd    // Port 0 input
);
   logic [7:0] mem [256];
   logic [7:0] adr_r;
   logic [7:0] last_r = 8'h00;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
   always @(posedge as_n) adr_r <= pins.p6_out;
   always @(posedge ds_n) if (!rw) mem[adr_r] <= pins.p0_out;
   // data only in strobe; released bus shows inverse
   assign rd = (!ds_n && rw) ? mem[adr_r] : ~last_r;
   always @(posedge clk) last_r <= rd;
endmodule // mem_model

//--- verification/tb_top.sv
// Testbench for the external bus strobe block
`timescale 1ns/1ps
module tb_top;
   import ext_bus_pkg::*;
   typedef struct packed {bus_req_s rq; logic chk; logic [7:0] exp;} row_s;
   logic        clk, rst_b, bus_float, req_valid, req_ready, rsp_valid, vec_done;
   logic        address_strobe_n, as_oe_n, data_strobe_n, ds_oe_n, rw, rw_oe_n, data_space;
   logic [7:0]  rsp_rdata, p0_in;
   logic [15:0] start_addr;
   bus_req_s    req;
   bus_pins_s   pins;
   int          n_errors = 0;
   int          n_compared = 0;
   row_s rows [6] = '{'{'{1, 0, 0, 16'h1234, 8'h3C}, 0, 8'h00}, '{'{0, 0, 0, 16'h1234, 8'h00}, 1, 8'h3C},
                      '{'{1, 0, 1, 16'h0010, 8'hFF}, 0, 8'h00}, '{'{0, 0, 0, 16'h0010, 8'h00}, 1, 8'hB5},
                      '{'{0, 1, 0, 16'h8077, 8'h00}, 1, 8'hD2}, '{'{0, 0, 1, 16'h0020, 8'h00}, 0, 8'h00}};
   ext_bus_strobes u_ext_bus_strobes (.clk, .rst_b, .bus_float, .req_valid, .req, .req_ready, .rsp_valid,
      .rsp_rdata, .vec_done, .start_addr, .address_strobe_n, .as_oe_n, .data_strobe_n, .ds_oe_n, .rw,
      .rw_oe_n, .data_space, .pins, .p0_in);
   mem_model u_mem_model (.clk, .as_n(address_strobe_n), .ds_n(data_strobe_n), .rw, .pins, .rd(p0_in));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Bounded wait for a flag
   task automatic wait_on(ref logic f);
      for (int k = 0; k < 40 && f !== 1'b1; k++) begin @(posedge clk); #2; end
   endtask
   // Hold the request until ready was sampled high
   task automatic cyc(input row_s w);
      req = w.rq;
      req_valid = 1'b1;
      wait_on(req_ready);
      chk({pins.p1_out, pins.p6_out}, w.rq.addr);
      chk(rw, !(w.rq.write && !w.rq.internal));
      chk(data_space, w.rq.data_space);
      @(posedge clk); #2;
      req_valid = 1'b0;
      wait_on(rsp_valid);
      chk(rsp_valid, 16'h0001);
      if (w.chk) chk(rsp_rdata, w.exp);
      @(posedge clk); #2;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Hang guard
   initial begin
      #400000;
      n_errors++;
      wrap_up;
   end
   initial begin
      rst_b = 1'b0; bus_float = 1'b0; req_valid = 1'b0; req = '0;
      repeat (2) @(posedge clk); #2;
      chk({address_strobe_n, data_strobe_n, rw}, 16'h0007);
      rst_b = 1'b1;
      wait_on(vec_done);
      chk(start_addr, 16'hA5A4);
      foreach (rows[i]) cyc(rows[i]);
      // Float while idle; no cycle may start
      bus_float = 1'b1;
      req = rows[1].rq;
      repeat (3) @(posedge clk); #2;
      chk({10'h000, as_oe_n, ds_oe_n, rw_oe_n, &pins.p1_oe_n, &pins.p6_oe_n, &pins.p0_oe_n}, 16'h003F);
      req_valid = 1'b1;
      repeat (8) begin @(posedge clk); #2; chk(req_ready, 16'h0000); end
      req_valid = 1'b0;
      @(posedge clk); #2;
      bus_float = 1'b0;
      cyc(rows[1]);
      // Second reset mid-run refetches the vector
      rst_b = 1'b0;
      @(posedge clk); #2;
      chk({vec_done, data_strobe_n}, 16'h0001);
      rst_b = 1'b1;
      wait_on(vec_done);
      chk(start_addr, 16'hA5A4);
      cyc(rows[4]);
      wrap_up;
   end
endmodule // tb_top
bind ext_bus_strobes bus_chk u_bus_chk (.clk, .rst_b, .req_valid, .req, .req_ready, .vec_done, .address_strobe_n,
   .as_oe_n, .data_strobe_n, .ds_oe_n, .rw, .rw_oe_n, .data_space, .pins);
